// ===== design/bfp_pkg.sv
`default_nettype none
package bfp_pkg;
	// Timing base
	localparam int CLK_HZ = 40_000_000;
	localparam int CYCLE_MS = 5;
	localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
	localparam int TICK_W = 18;
	localparam int DLY_W = 19;
	// Widths and scaling
	localparam int MAG_W = 16;
	localparam int PTHR_W = 12;
	localparam int RTHR_W = 16;
	localparam int MASK_W = 16;
	localparam int AW = 8;
	localparam int CMP_W = 24;
	localparam int NCH = 4;
	localparam int RES_CH = 3;
	localparam logic [CMP_W-1:0] PH_SCALE = 24'h00_000a;
	localparam logic [CMP_W-1:0] RESET_PCT = 24'h00_0061;
	localparam logic [CMP_W-1:0] FULL_PCT = 24'h00_0064;
	// Register byte offsets
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_PTHR = 8'h04;
	localparam logic [AW-1:0] A_RTHR = 8'h08;
	localparam logic [AW-1:0] A_RDLY = 8'h0c;
	localparam logic [AW-1:0] A_BDLY = 8'h10;
	localparam logic [AW-1:0] A_SMSK = 8'h14;
	localparam logic [AW-1:0] A_DMSK = 8'h18;
	localparam logic [AW-1:0] A_STAT = 8'h1c;
	localparam logic [AW-1:0] A_EVT = 8'h20;
	// Modes and states
	typedef enum logic [1:0] {
		RES_UNUSED = 2'h0, RES_FIRST = 2'h1, RES_SECOND = 2'h2, RES_CALC = 2'h3
	} bfp_res_sel_t;
	typedef enum logic [3:0] {
		OM_CUR = 4'h0, OM_DO = 4'h1, OM_SIG = 4'h2, OM_CUR_AND_DO = 4'h3,
		OM_CUR_OR_DO = 4'h4, OM_CUR_AND_SIG = 4'h5, OM_CUR_OR_SIG = 4'h6,
		OM_SIG_AND_DO = 4'h7, OM_SIG_OR_DO = 4'h8, OM_ALL_AND = 4'h9,
		OM_ALL_OR = 4'ha
	} bfp_op_mode_t;
	typedef enum logic [2:0] {
		LN_ON = 3'h0, LN_BLOCKED = 3'h1, LN_TEST = 3'h2, LN_TEST_BLK = 3'h3,
		LN_OFF = 3'h4
	} bfp_ln_t;
	typedef enum logic [2:0] {
		CD_NORMAL = 3'h0, CD_START = 3'h1, CD_RETRIP = 3'h2, CD_BFAIL = 3'h3,
		CD_ON = 3'h4, CD_BLOCKED = 3'h5
	} bfp_cond_t;
	// Register words
	typedef struct packed {
		logic [21:0] pad;
		bfp_ln_t ln;
		logic retrip_en;
		bfp_res_sel_t res_sel;
		bfp_op_mode_t mode;
	} bfp_ctrl_t;
	typedef struct packed {
		logic [20:0] pad;
		logic pickup;
		logic blocked;
		logic bfail;
		logic retrip;
		logic start;
		bfp_ln_t ln;
		bfp_cond_t cond;
	} bfp_status_t;
	typedef struct packed {
		logic [27:0] pad;
		logic blocked;
		logic bfail;
		logic retrip;
		logic start;
	} bfp_event_t;
	typedef struct packed {
		logic [2:0][MAG_W-1:0] phase;
		logic [MAG_W-1:0] res_first;
		logic [MAG_W-1:0] res_second;
		logic [MAG_W-1:0] res_calc;
	} bfp_meas_t;
	typedef struct packed {
		bfp_ctrl_t ctrl;
		logic [PTHR_W-1:0] ph_thr;
		logic [RTHR_W-1:0] res_thr;
		logic [DLY_W-1:0] retrip_dly;
		logic [DLY_W-1:0] bfail_dly;
		logic [MASK_W-1:0] sig_mask;
		logic [MASK_W-1:0] do_mask;
		bfp_event_t evt;
	} bfp_regs_t;
	// Reset values
	localparam bfp_ctrl_t CTRL_RST = '{pad: '0, ln: LN_ON, retrip_en: 1'b1,
		res_sel: RES_UNUSED, mode: OM_CUR};
	localparam logic [PTHR_W-1:0] PTHR_RST = 12'h014;
	localparam logic [RTHR_W-1:0] RTHR_RST = 16'h04b0;
	localparam logic [DLY_W-1:0] RDLY_RST = 19'h0_0014;
	localparam logic [DLY_W-1:0] BDLY_RST = 19'h0_0028;
	localparam bfp_regs_t REGS_RST = '{ctrl: CTRL_RST, ph_thr: PTHR_RST,
		res_thr: RTHR_RST, retrip_dly: RDLY_RST, bfail_dly: BDLY_RST,
		sig_mask: '0, do_mask: '0, evt: '0};
endpackage : bfp_pkg
`default_nettype wire

// ===== design/bfp_top.sv
// Behaviour
// R1: Current pick-up releases only below 97 percent of its threshold.
// R2: Three phases and chosen residual compared; one shared phase threshold.
// R3: Any one, two or three phases above threshold give pick-up.
// R4: Residual source: unused, first, second or computed; default unused.
// R5: Operating mode combines current, signals, outputs by AND/OR; default current.
// R6: Phase threshold 0.01 to 40.00 nominal, step 0.01, default 0.20.
// R7: Residual threshold 0.005 to 40.000, step 0.001, default 1.200.
// R8: Setting changes act while running, with no restart.
// R9: Block input sampled at the start of every program cycle.
// R10: Pick-up without block raises start and begins timing.
// R11: Pick-up with block raises blocked and does nothing more.
// R12: Block arriving during start drops start and releases like pick-up reset.
// R13: Block must arrive 5 ms before the delay expires.
// R14: One common pick-up starts retrip and breaker failure timers.
// R15: Breaker failure delay should exceed retrip plus breaker and release times.
// R16: Retrip enable, default yes; disabled means no retrip output.
// R17: Retrip after pick-up lasts retrip delay; 0 to 1800 s, 5 ms steps.
// R18: Breaker failure after its delay; same range, default 0.200 s.
// R19: Condition reports normal, started, retrip, failure, on or blocked.
// R20: Node behaviour reports on, blocked, test, test-blocked or off.
// R21: Magnitudes compared on a 5 ms time base.
// R22: Selected trip signals start countdown only in modes with signals.
// R23: Pick-up release clears both timers and both delayed outputs.
`timescale 1ns/1ps
`default_nettype none
module bfp_top #(
	parameter int CYCLE_CLKS = bfp_pkg::CYCLE_CLKS,
	parameter int N_SIG = 16,
	parameter int N_DO = 16
) (
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Measurement and monitored signals
	input wire bfp_pkg::bfp_meas_t i_meas,
	input wire logic [N_SIG-1:0] i_trip_sig,
	input wire logic [N_DO-1:0] i_do_state,
	input wire logic i_block,
	// Function outputs
	output logic o_start,
	output logic o_blocked,
	output logic o_retrip,
	output logic o_breaker_failure_output,
	output bfp_pkg::bfp_cond_t o_condition,
	output bfp_pkg::bfp_ln_t o_logical_node_behaviour,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [bfp_pkg::AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr
);
	import bfp_pkg::*;

	// Parameter sanity, refused at elaboration
	if (CYCLE_CLKS < 2 || CYCLE_CLKS > (1 << TICK_W)) begin : g_bad_cycle
		$error("CYCLE_CLKS out of range");
	end
	if (N_SIG < 1 || N_SIG > MASK_W
		|| N_DO < 1 || N_DO > MASK_W) begin : g_bad_n
		$error("N_SIG or N_DO out of range");
	end

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLE_CLKS - 1);
	localparam logic [DLY_W-1:0] DLY_MAX = '1;

	typedef struct packed {
		bfp_regs_t regs;
		logic [TICK_W-1:0] tick_cnt;
		logic [NCH-1:0] pick;
		logic start;
		logic blocked;
		logic retrip;
		logic bfail;
		logic pickup;
		logic [DLY_W-1:0] elapsed;
		bfp_cond_t cond;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} bfp_state_t;

	localparam bfp_state_t ST_RST = '{regs: REGS_RST, tick_cnt: '0,
		pick: '0, start: 1'b0, blocked: 1'b0, retrip: 1'b0, bfail: 1'b0,
		pickup: 1'b0, elapsed: '0, cond: CD_NORMAL, pready: 1'b0,
		pslverr: 1'b0, prdata: '0};

	bfp_state_t st;
	bfp_state_t next_st;
	logic tick;
	logic [MAG_W-1:0] res_mag;
	logic [NCH-1:0] next_pick;
	logic pu_now;
	logic blk_now;

	// Operating mode combiner
	function automatic logic mode_pick(bfp_op_mode_t m, logic c, logic s,
		logic d);
		logic r;
		r = 1'b0;
		unique case (m)
			OM_CUR: r = c;
			OM_DO: r = d;
			OM_SIG: r = s;
			OM_CUR_AND_DO: r = c & d;
			OM_CUR_OR_DO: r = c | d;
			OM_CUR_AND_SIG: r = c & s;
			OM_CUR_OR_SIG: r = c | s;
			OM_SIG_AND_DO: r = s & d;
			OM_SIG_OR_DO: r = s | d;
			OM_ALL_AND: r = c & s & d;
			OM_ALL_OR: r = c | s | d;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : mode_pick

	// Residual source selector
	always_comb begin
		unique case (st.regs.ctrl.res_sel) // see R4
			RES_FIRST: res_mag = i_meas.res_first;
			RES_SECOND: res_mag = i_meas.res_second;
			RES_CALC: res_mag = i_meas.res_calc;
			RES_UNUSED: res_mag = '0;
		endcase
	end

	// Per-channel comparator with 97 percent release
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic [CMP_W-1:0] mag;
		logic [CMP_W-1:0] thr;
		logic en;
		if (g < RES_CH) begin : g_ph
			assign mag = CMP_W'(i_meas.phase[g]);
			assign thr = CMP_W'(st.regs.ph_thr) * PH_SCALE; // see R2
			assign en = 1'b1;
		end else begin : g_res
			assign mag = CMP_W'(res_mag);
			assign thr = CMP_W'(st.regs.res_thr);
			assign en = st.regs.ctrl.res_sel != RES_UNUSED;
		end
		always_comb begin
			if (!en)
				next_pick[g] = 1'b0;
			else if (mag > thr)
				next_pick[g] = 1'b1;
			else if (mag * FULL_PCT < thr * RESET_PCT) // see R1
				next_pick[g] = 1'b0;
			else
				next_pick[g] = st.pick[g];
		end
	end

	assign tick = st.tick_cnt == TICK_LAST;

	// Next-state logic
	always_comb begin
		logic acc;
		logic hit;
		logic [31:0] rd;
		logic cur;
		logic sig;
		logic dos;
		logic [DLY_W-1:0] el;
		bfp_event_t clr;
		acc = i_psel & i_penable;
		hit = 1'b1;
		rd = '0;
		cur = 1'b0;
		sig = 1'b0;
		dos = 1'b0;
		el = '0;
		clr = '0;
		pu_now = 1'b0;
		blk_now = 1'b0;
		next_st = st;
		// Program cycle counter
		next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
		// Register decode
		unique case (i_paddr)
			A_CTRL: rd = 32'(st.regs.ctrl);
			A_PTHR: rd = 32'(st.regs.ph_thr);
			A_RTHR: rd = 32'(st.regs.res_thr);
			A_RDLY: rd = 32'(st.regs.retrip_dly);
			A_BDLY: rd = 32'(st.regs.bfail_dly);
			A_SMSK: rd = 32'(st.regs.sig_mask);
			A_DMSK: rd = 32'(st.regs.do_mask);
			A_STAT: rd = 32'(bfp_status_t'{pad: '0, pickup: st.pickup,
				blocked: st.blocked, bfail: st.bfail, retrip: st.retrip,
				start: st.start, ln: st.regs.ctrl.ln, cond: st.cond});
			A_EVT: rd = 32'(st.regs.evt);
			default: hit = 1'b0;
		endcase
		// APB: one wait state, data and error registered
		next_st.pready = acc & ~st.pready;
		if (acc && !st.pready) begin
			next_st.prdata = hit ? rd : '0;
			next_st.pslverr = ~hit;
		end
		// Writes land at the completing edge, live settings
		if (acc && st.pready && i_pwrite) begin // see R8
			unique case (i_paddr)
				A_CTRL: begin
					next_st.regs.ctrl = bfp_ctrl_t'(i_pwdata);
					next_st.regs.ctrl.pad = '0;
				end
				A_PTHR: next_st.regs.ph_thr = i_pwdata[PTHR_W-1:0]; // see R6
				A_RTHR: next_st.regs.res_thr = i_pwdata[RTHR_W-1:0]; // see R7
				A_RDLY: next_st.regs.retrip_dly = i_pwdata[DLY_W-1:0];
				A_BDLY: next_st.regs.bfail_dly = i_pwdata[DLY_W-1:0];
				A_SMSK: next_st.regs.sig_mask = i_pwdata[MASK_W-1:0];
				A_DMSK: next_st.regs.do_mask = i_pwdata[MASK_W-1:0];
				A_EVT: clr = bfp_event_t'(i_pwdata);
				default: ;
			endcase
		end
		next_st.regs.evt = st.regs.evt & ~clr;
		// Pick-up and block, combined once per program cycle
		cur = |next_pick; // see R3
		sig = |(i_trip_sig & st.regs.sig_mask[N_SIG-1:0]); // see R22
		dos = |(i_do_state & st.regs.do_mask[N_DO-1:0]);
		pu_now = mode_pick(st.regs.ctrl.mode, cur, sig, dos); // see R5
		blk_now = i_block || st.regs.ctrl.ln == LN_BLOCKED
			|| st.regs.ctrl.ln == LN_TEST_BLK;
		if (tick) begin
			next_st.pick = next_pick; // see R21
			el = (st.elapsed == DLY_MAX) ? st.elapsed : st.elapsed + 1'b1;
			if (st.regs.ctrl.ln == LN_OFF) begin
				next_st.pick = '0;
				next_st.pickup = 1'b0;
				next_st.start = 1'b0;
				next_st.blocked = 1'b0;
				next_st.retrip = 1'b0;
				next_st.bfail = 1'b0;
				next_st.elapsed = '0;
			end else if (pu_now && !blk_now) begin // see R9
				next_st.pickup = 1'b1;
				next_st.start = 1'b1; // see R10
				next_st.blocked = 1'b0;
				next_st.elapsed = st.start ? el : '0; // see R14
				next_st.retrip = st.regs.ctrl.retrip_en // see R16
					&& next_st.elapsed >= st.regs.retrip_dly; // see R17
				next_st.bfail = next_st.elapsed >= st.regs.bfail_dly; // see R18
			end else begin
				// Release path, also taken when block arrives
				next_st.pickup = pu_now;
				next_st.start = 1'b0; // see R12
				next_st.blocked = pu_now; // see R11
				next_st.retrip = 1'b0; // see R23
				next_st.bfail = 1'b0;
				next_st.elapsed = '0;
			end
			// Sticky events, set wins over clear
			next_st.regs.evt.start = next_st.regs.evt.start
				| (next_st.start & ~st.start);
			next_st.regs.evt.retrip = next_st.regs.evt.retrip
				| (next_st.retrip & ~st.retrip);
			next_st.regs.evt.bfail = next_st.regs.evt.bfail
				| (next_st.bfail & ~st.bfail);
			next_st.regs.evt.blocked = next_st.regs.evt.blocked
				| (next_st.blocked & ~st.blocked);
			// Reported condition
			if (next_st.blocked) // see R19
				next_st.cond = CD_BLOCKED;
			else if (next_st.bfail)
				next_st.cond = CD_BFAIL;
			else if (next_st.retrip)
				next_st.cond = CD_RETRIP;
			else if (next_st.start)
				next_st.cond = CD_START;
			else if (st.regs.ctrl.ln == LN_TEST)
				next_st.cond = CD_ON;
			else
				next_st.cond = CD_NORMAL;
		end
	end

	// State register, frozen while enable is low
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			st <= ST_RST;
		else if (i_ce)
			st <= next_st;
	end

	// Outputs straight from state
	assign o_start = st.start;
	assign o_blocked = st.blocked;
	assign o_retrip = st.retrip;
	assign o_breaker_failure_output = st.bfail;
	assign o_condition = st.cond;
	assign o_logical_node_behaviour = st.regs.ctrl.ln; // see R20
	assign o_pready = st.pready;
	assign o_prdata = st.prdata;
	assign o_pslverr = st.pslverr;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	logic tick_ce;
	logic ln_run;
	assign tick_ce = tick & i_ce;
	assign ln_run = st.regs.ctrl.ln != LN_OFF;

	chk_release_hyst: assert property ( // see R1
		tick_ce && ln_run && g_ch[0].en && st.pick[0]
		&& g_ch[0].mag * FULL_PCT >= g_ch[0].thr * RESET_PCT
		|=> st.pick[0])
		else $error("phase pick-up released above 97 percent");

	chk_start_pickup: assert property ( // see R10
		tick_ce && ln_run && pu_now && !blk_now |=> o_start && !o_blocked)
		else $error("start missing after unblocked pick-up");

	chk_blocked_only: assert property ( // see R11
		tick_ce && ln_run && pu_now && blk_now
		|=> o_blocked && !o_start && !o_retrip && !o_breaker_failure_output)
		else $error("blocked pick-up still acted");

	chk_release_clear: assert property ( // see R23
		tick_ce && !pu_now
		|=> !o_start && !o_retrip && !o_breaker_failure_output
		&& st.elapsed == '0)
		else $error("release left timers or outputs set");

	chk_retrip_off: assert property ( // see R16
		tick_ce && !st.regs.ctrl.retrip_en |=> !o_retrip)
		else $error("retrip raised while disabled");

	chk_retrip_delay: assert property ( // see R17
		$rose(o_retrip) |-> o_start && st.elapsed >= st.regs.retrip_dly
		&& $past(tick))
		else $error("retrip before its delay");

	chk_bfail_delay: assert property ( // see R18
		$rose(o_breaker_failure_output)
		|-> o_start && st.elapsed >= st.regs.bfail_dly)
		else $error("breaker failure before its delay");

	chk_common_timer: assert property ( // see R14
		$rose(o_start) |-> st.elapsed == '0)
		else $error("timers not started from zero");

	chk_cycle_sample: assert property ( // see R9
		!tick_ce |=> $stable(o_start) && $stable(o_blocked))
		else $error("status moved between program cycles");

	chk_ce_freeze: assert property (
		!i_ce |=> $stable(st))
		else $error("state changed with enable low");

	chk_condition: assert property ( // see R19
		o_breaker_failure_output && !o_blocked |-> o_condition == CD_BFAIL)
		else $error("condition does not show breaker failure");

	chk_apb_wait: assert property (
		i_psel && i_penable && !o_pready |=> o_pready)
		else $error("APB answer not given after one wait state");

	chk_event_start: assert property ( // see R10
		$rose(o_start) |-> st.regs.evt.start)
		else $error("start event not recorded");

	chk_res_unused: assert property ( // see R4
		tick_ce && st.regs.ctrl.res_sel == RES_UNUSED
		|=> !st.pick[RES_CH])
		else $error("unused residual produced pick-up");

	chk_off_quiet: assert property ( // see R20
		tick_ce && !ln_run |=> !o_start && !o_blocked && !o_retrip)
		else $error("outputs active with node off");
endmodule : bfp_top
`default_nettype wire

// ===== tb/bfp_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfp_stage_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Fault scenario from the bench
	input wire logic [bfp_pkg::MAG_W-1:0] i_ph_mag,
	input wire logic [2:0] i_ph_sel,
	input wire logic [bfp_pkg::MAG_W-1:0] i_res_mag,
	input wire logic [1:0] i_res_src,
	input wire logic i_sig,
	input wire logic i_do,
	input wire logic i_blk,
	// Toward the supervision block
	output var bfp_pkg::bfp_meas_t o_meas,
	output var logic [15:0] o_trip_sig,
	output var logic [15:0] o_do_state,
	output var logic o_block
);
	import bfp_pkg::*;
	// Healthy phases carry load current below the default threshold
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_meas <= '0;
			o_trip_sig <= '0;
			o_do_state <= '0;
			o_block <= 1'b0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				o_meas.phase[p] <= i_ph_sel[p] ? i_ph_mag : 16'h0064;
			end
			o_meas.res_first <= (i_res_src == 2'h1) ? i_res_mag : '0;
			o_meas.res_second <= (i_res_src == 2'h2) ? i_res_mag : '0;
			o_meas.res_calc <= (i_res_src == 2'h3) ? i_res_mag : '0;
			o_trip_sig <= {15'h0000, i_sig};
			o_do_state <= {15'h0000, i_do};
			o_block <= i_blk; // Ticks ahead of expiry
		end
	end
endmodule : bfp_stage_model
`default_nettype wire

// ===== tb/breaker_failure_protection_test.sv
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_protection_test;
	import bfp_pkg::*;
	localparam int CYC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [15:0] ph_mag = 16'h0064;
	logic [2:0] ph_sel = 3'h0;
	logic [15:0] res_mag = 16'h0000;
	logic [1:0] res_src = 2'h0;
	logic sig = 1'b0;
	logic dov = 1'b0;
	logic blk = 1'b0;
	logic ce = 1'b1;
	bfp_meas_t meas;
	logic [15:0] trip_sig;
	logic [15:0] do_state;
	logic block;
	logic o_start, o_blocked, o_retrip, o_bfail, pready, pslverr;
	bfp_cond_t o_condition;
	bfp_ln_t o_node;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic slverr;
	int errors = 0;
	int samples_checked = 0;

	// 40 MHz core clock
	always #12.5 clk = ~clk;

	bfp_stage_model bfp_stage_model_i (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_ph_mag(ph_mag), .i_ph_sel(ph_sel), .i_res_mag(res_mag),
		.i_res_src(res_src), .i_sig(sig), .i_do(dov), .i_blk(blk),
		.o_meas(meas), .o_trip_sig(trip_sig), .o_do_state(do_state),
		.o_block(block));

	bfp_top #(.CYCLE_CLKS(CYC)) bfp_top_i (.i_core_clk(clk),
		.i_rst_n(rst_n), .i_ce(ce), .i_meas(meas), .i_trip_sig(trip_sig),
		.i_do_state(do_state), .i_block(block), .o_start(o_start),
		.o_blocked(o_blocked), .o_retrip(o_retrip),
		.o_breaker_failure_output(o_bfail), .o_condition(o_condition),
		.o_logical_node_behaviour(o_node), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr));

	task results;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask : chk

	task done(input string m);
		$display("test %s finished", m);
	endtask : done

	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			chk(32'h0000_0000, 32'h0000_0001, "bus timeout");
			results();
		end
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdata & k, e, "read");
	endtask : rd

	function automatic logic [31:0] ctrl(input logic [3:0] m,
		input logic [1:0] r, input logic t, input logic [2:0] l);
		return {22'h00_0000, l, t, r, m};
	endfunction : ctrl

	task stim(input logic [15:0] m, input logic [2:0] s, input logic b);
		@(posedge clk);
		ph_mag <= m;
		ph_sel <= s;
		blk <= b;
	endtask : stim

	task ticks(input int t);
		repeat (t * CYC) @(posedge clk);
		#1;
	endtask : ticks

	function automatic logic outv(input int w);
		case (w)
			0: return o_start;
			1: return o_retrip;
			2: return o_bfail;
			default: return o_blocked;
		endcase
	endfunction : outv

	// Bounded wait for one output level, counting edges
	task wait_for(input int w, input logic v, output int n);
		n = 0;
		while (outv(w) !== v && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 400) begin
			chk(32'h0000_0000, 32'h0000_0001, "wait timeout");
			results();
		end
	endtask : wait_for

	task t_reset;
		rd(A_CTRL, '1, 32'h0000_0040);
		rd(A_PTHR, '1, 32'h0000_0014);
		rd(A_RTHR, '1, 32'h0000_04b0);
		rd(A_RDLY, '1, 32'h0000_0014);
		rd(A_BDLY, '1, 32'h0000_0028);
		rd(A_STAT, '1, 32'h0000_0000);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk({31'h0, slverr}, 32'h0000_0001, "unmapped");
		wr(A_CTRL, ctrl(4'h0, 2'h0, 1'b1, 3'h2));
		ticks(2);
		chk(32'(o_condition), 32'(CD_ON), "test idle");
		wr(A_CTRL, 32'h0000_0040);
		done("reset");
	endtask : t_reset

	task t_timing;
		int n;
		wr(A_RDLY, 32'h0000_0003);
		wr(A_BDLY, 32'h0000_0005);
		stim(16'h00c8, 3'b100, 1'b0);
		ticks(3);
		rd(A_STAT, 32'h0000_0400, 32'h0000_0000);
		stim(16'h00c9, 3'b110, 1'b0);
		wait_for(0, 1'b1, n);
		chk(32'(o_condition), 32'(CD_START), "start");
		wait_for(1, 1'b1, n);
		chk(n, 3 * CYC, "retrip delay");
		chk(32'(o_condition), 32'(CD_RETRIP), "retrip");
		wait_for(2, 1'b1, n);
		chk(n, 2 * CYC, "failure delay");
		chk(32'(o_condition), 32'(CD_BFAIL), "failure");
		rd(A_EVT, '1, 32'h0000_0007);
		wr(A_EVT, 32'h0000_000f);
		rd(A_EVT, '1, 32'h0000_0000);
		stim(16'h00c2, 3'b010, 1'b0);
		ticks(3);
		chk(o_bfail, 1'b1, "hysteresis");
		wr(A_PTHR, 32'h0000_001e);
		wait_for(2, 1'b0, n);
		chk({o_start, o_retrip}, 32'h0000_0000, "release");
		wr(A_PTHR, 32'h0000_0014);
		stim(16'h0064, 3'b000, 1'b0);
		done("timing");
	endtask : t_timing

	task t_block;
		int n;
		stim(16'h012c, 3'b001, 1'b1);
		wait_for(3, 1'b1, n);
		chk(o_start, 1'b0, "blocked start");
		chk(32'(o_condition), 32'(CD_BLOCKED), "blocked");
		stim(16'h012c, 3'b001, 1'b0);
		wait_for(0, 1'b1, n);
		stim(16'h012c, 3'b001, 1'b1);
		wait_for(0, 1'b0, n);
		chk({o_retrip, o_blocked}, 32'h0000_0001, "late block");
		stim(16'h0064, 3'b000, 1'b0);
		wait_for(3, 1'b0, n);
		done("block");
	endtask : t_block

	task t_residual;
		int n;
		for (int s = 1; s < 4; s++) begin
			for (int q = 0; q < 4; q++) begin
				wr(A_CTRL, ctrl(4'h0, 2'(q), 1'b1, 3'h0));
				@(posedge clk);
				res_src <= 2'(s);
				res_mag <= 16'h04b1;
				ticks(3);
				rd(A_STAT, 32'h0000_0400, {21'h0, s == q, 10'h0});
			end
		end
		@(posedge clk);
		res_mag <= 16'h0000;
		wr(A_CTRL, 32'h0000_0040);
		wait_for(0, 1'b0, n);
		done("residual");
	endtask : t_residual

	task t_modes;
		int n;
		logic [1:0][11:0] pick;
		pick = {12'h55b, 12'h544};
		wr(A_SMSK, 32'h0000_0001);
		wr(A_DMSK, 32'h0000_0001);
		// Signal alone first, then current with output relay
		for (int v = 0; v < 2; v++) begin
			@(posedge clk);
			dov <= 1'(v);
			sig <= 1'(1 - v);
			stim(v ? 16'h00c9 : 16'h0064, v ? 3'b001 : 3'b000, 1'b0);
			for (int m = 0; m < 12; m++) begin
				wr(A_CTRL, ctrl(4'(m), 2'h0, 1'b1, 3'h0));
				ticks(3);
				rd(A_STAT, 32'h0000_0400,
					{21'h0, pick[v][m], 10'h0});
			end
		end
		for (int l = 0; l < 5; l++) begin
			wr(A_CTRL, ctrl(4'h0, 2'h0, 1'b1, 3'(l)));
			ticks(3);
			chk(32'(o_node), l, "node");
			chk(o_start, 32'(l == 0 || l == 2), "node start");
		end
		wr(A_CTRL, 32'h0000_0040);
		stim(16'h0064, 3'b000, 1'b0);
		dov <= 1'b0;
		wait_for(0, 1'b0, n);
		done("modes");
	endtask : t_modes

	task t_noretrip;
		int n;
		wr(A_CTRL, ctrl(4'h0, 2'h0, 1'b0, 3'h0));
		stim(16'h00c9, 3'b100, 1'b0);
		wait_for(2, 1'b1, n);
		chk(o_retrip, 1'b0, "retrip off");
		stim(16'h0064, 3'b000, 1'b0);
		wr(A_CTRL, 32'h0000_0040);
		wait_for(0, 1'b0, n);
		done("noretrip");
	endtask : t_noretrip

	// Enable low holds the program cycle and all outputs
	task t_freeze;
		int n;
		@(posedge clk);
		ce <= 1'b0;
		stim(16'h00c9, 3'b001, 1'b0);
		ticks(3);
		chk(o_start, 1'b0, "frozen start");
		@(posedge clk);
		ce <= 1'b1;
		wait_for(0, 1'b1, n);
		chk(n <= CYC, 1'b1, "thawed start");
		stim(16'h0064, 3'b000, 1'b0);
		wait_for(0, 1'b0, n);
		done("freeze");
	endtask : t_freeze

	// Reset, then the scenarios in turn
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_timing();
		t_block();
		t_residual();
		t_modes();
		t_noretrip();
		t_freeze();
		results();
	end
endmodule : breaker_failure_protection_test
`default_nettype wire
